// ---- rtl/rnp_pkg.sv ----
package rnp_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RST_REJECT_NS = 10;
    localparam int RST_ACCEPT_NS = 100;
    // a pulse shorter than the reject time spans at most
    // reject/period + 1 clock edges, so one more sample is demanded
    localparam int RST_FILT_CYC = RST_REJECT_NS / CLK_PERIOD_NS + 2;
    localparam int SYNC_STAGES = 2;
    localparam int CFG_W = 2;
    localparam logic [CFG_W-1:0] CFG_RST_VAL = 2'h0;
    localparam logic [3:0] FILT_CNT_RST = 4'h0;
    typedef logic [CFG_W-1:0] rnp_cfg_t;
    typedef enum logic [1:0] {
        ST_IN_RESET,
        ST_RUN,
        ST_POWER_DOWN
    } rnp_state_t;
endpackage

// ---- rtl/rnp_in_if.sv ----
interface rnp_in_if;
    logic rst_req;
    logic nmi_lvl;
    modport src (output rst_req, output nmi_lvl);
    modport dst (input rst_req, input nmi_lvl);
endinterface

// ---- rtl/rnp_sync_filt.sv ----
module rnp_sync_filt
    import rnp_pkg::*;
#(
    parameter int FILT_CYC = RST_FILT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ext_reset_in_n,
    input wire logic nmi_in,
    rnp_in_if.src sync_out
);
    import rnp_pkg::*;

    logic s1_rst_n_r, s2_rst_n_r, s1_nmi_r, s2_nmi_r;
    logic [3:0] low_cnt_r, low_cnt_nxt;
    logic req_r, req_nxt;

    // spike filter on the synchronised reset level
    always_comb begin
        low_cnt_nxt = low_cnt_r;
        req_nxt = req_r;
        if (s2_rst_n_r) begin
            low_cnt_nxt = FILT_CNT_RST;
            req_nxt = 1'b0;
        end else if (low_cnt_r == 4'(FILT_CYC - 1)) begin
            req_nxt = 1'b1;
        end else begin
            low_cnt_nxt = low_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_rst_n_r <= 1'b0;
            s2_rst_n_r <= 1'b0;
            s1_nmi_r <= 1'b1;
            s2_nmi_r <= 1'b1;
            low_cnt_r <= FILT_CNT_RST;
            req_r <= 1'b1;
        end else if (clk_en) begin
            s1_rst_n_r <= ext_reset_in_n;
            s2_rst_n_r <= s1_rst_n_r;
            s1_nmi_r <= nmi_in;
            s2_nmi_r <= s1_nmi_r;
            low_cnt_r <= low_cnt_nxt;
            req_r <= req_nxt;
        end
    end

    assign sync_out.rst_req = req_r;
    assign sync_out.nmi_lvl = s2_nmi_r;

    AST_FILT_REJECT: assert property (
        @(posedge ref_clk) disable iff (rst)
        (req_r && !$past(req_r)) |->
        (!$past(s2_rst_n_r, 1) && !$past(s2_rst_n_r, 2)
        && !$past(s2_rst_n_r, 3)))
        else $error("reset request raised without enough low samples");

    AST_NMI_SYNC: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en ##1 clk_en |=> s2_nmi_r == $past(nmi_in, 2))
        else $error("nmi level not delayed by two stages");

    AST_SYNC_FREEZE: assert property (
        @(posedge ref_clk) disable iff (rst)
        !clk_en |=> $stable(s2_rst_n_r) && $stable(s2_nmi_r) && $stable(req_r))
        else $error("synchroniser moved while clock enable low");
endmodule

// ---- rtl/rnp_reset_nmi_pd.sv ----
module rnp_reset_nmi_pd
    import rnp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ext_reset_in_n,
    input wire logic osc_running,
    input wire logic nmi_in,
    input wire logic power_down_instruction,
    input wire logic startup_config_pin_a,
    input wire logic startup_config_pin_b,
    output logic sys_reset_r,
    output logic nmi_trap_r,
    output logic power_down_r,
    output logic pd_ignored_r,
    output rnp_pkg::rnp_cfg_t startup_cfg_r,
    output logic cfg_valid_r
);
    import rnp_pkg::*;

    rnp_in_if sync_if ();

    rnp_sync_filt #(
        .FILT_CYC(RST_FILT_CYC)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .ext_reset_in_n(ext_reset_in_n),
        .nmi_in(nmi_in),
        .sync_out(sync_if.src)
    );

    rnp_state_t state_r, state_nxt;
    logic nmi_prev_r, nmi_prev_nxt;
    logic sys_reset_nxt, nmi_trap_nxt, power_down_nxt, pd_ignored_nxt;
    logic cfg_valid_nxt;
    rnp_cfg_t startup_cfg_nxt;
    logic reset_hit, nmi_fall;

    function automatic logic fall_seen(input logic prev, input logic now);
        return prev && !now;
    endfunction

    function automatic logic run_ok(input rnp_state_t st, input logic hit);
        return st == ST_RUN && !hit;
    endfunction

    function automatic rnp_cfg_t cfg_of(input logic pin_b, input logic pin_a);
        return {pin_b, pin_a};
    endfunction

    assign reset_hit = sync_if.rst_req && osc_running;
    assign nmi_fall = fall_seen(nmi_prev_r, sync_if.nmi_lvl);

    always_comb begin
        state_nxt = state_r;
        nmi_prev_nxt = sync_if.nmi_lvl;
        sys_reset_nxt = sys_reset_r;
        nmi_trap_nxt = 1'b0;
        power_down_nxt = power_down_r;
        pd_ignored_nxt = 1'b0;
        startup_cfg_nxt = startup_cfg_r;
        cfg_valid_nxt = cfg_valid_r;
        if (reset_hit) begin
            state_nxt = ST_IN_RESET;
            sys_reset_nxt = 1'b1;
            power_down_nxt = 1'b0;
            cfg_valid_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IN_RESET: begin
                    if (!sync_if.rst_req) begin
                        state_nxt = ST_RUN;
                        sys_reset_nxt = 1'b0;
                        startup_cfg_nxt = cfg_of(startup_config_pin_b,
                            startup_config_pin_a);
                        cfg_valid_nxt = 1'b1;
                    end
                end
                ST_RUN: begin
                    nmi_trap_nxt = nmi_fall;
                    if (power_down_instruction) begin
                        if (!sync_if.nmi_lvl) begin
                            state_nxt = ST_POWER_DOWN;
                            power_down_nxt = 1'b1;
                        end else begin
                            pd_ignored_nxt = 1'b1;
                        end
                    end
                end
                ST_POWER_DOWN: begin
                    power_down_nxt = 1'b1;
                end
                default: begin
                    state_nxt = ST_IN_RESET;
                    sys_reset_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IN_RESET;
            nmi_prev_r <= 1'b1;
            sys_reset_r <= 1'b1;
            nmi_trap_r <= 1'b0;
            power_down_r <= 1'b0;
            pd_ignored_r <= 1'b0;
            startup_cfg_r <= CFG_RST_VAL;
            cfg_valid_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            nmi_prev_r <= nmi_prev_nxt;
            sys_reset_r <= sys_reset_nxt;
            nmi_trap_r <= nmi_trap_nxt;
            power_down_r <= power_down_nxt;
            pd_ignored_r <= pd_ignored_nxt;
            startup_cfg_r <= startup_cfg_nxt;
            cfg_valid_r <= cfg_valid_nxt;
        end
    end

    AST_RESET_ENTER: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && sync_if.rst_req && osc_running |=>
        sys_reset_r && !power_down_r && !cfg_valid_r)
        else $error("reset request did not reset the core");

    AST_OSC_BLOCK: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && !osc_running && state_r != ST_IN_RESET |=> !sys_reset_r)
        else $error("reset taken while the oscillator was stopped");

    AST_FREEZE: assert property (
        @(posedge ref_clk) disable iff (rst)
        !clk_en |=> $stable(state_r) && $stable(sys_reset_r)
        && $stable(power_down_r) && $stable(nmi_trap_r)
        && $stable(pd_ignored_r) && $stable(startup_cfg_r))
        else $error("state moved while clock enable low");

    AST_NMI_TRAP: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && run_ok(state_r, reset_hit) && nmi_prev_r
        && !sync_if.nmi_lvl |=> nmi_trap_r
        ##1 (!nmi_trap_r || !$past(clk_en)))
        else $error("nmi fall did not give one trap pulse");

    AST_NO_FALSE_TRAP: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && !(nmi_prev_r && !sync_if.nmi_lvl) |=> !nmi_trap_r)
        else $error("trap raised without nmi fall");

    AST_TRAP_QUIET: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && state_r != ST_RUN |=> !nmi_trap_r)
        else $error("trap raised outside normal running");

    AST_TRAP_RUNNING: assert property (
        @(posedge ref_clk) disable iff (rst)
        nmi_trap_r |-> !sys_reset_r)
        else $error("trap pulse seen while the core was in reset");

    AST_PD_ENTER: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && run_ok(state_r, reset_hit) && power_down_instruction
        && !sync_if.nmi_lvl |=> power_down_r && !pd_ignored_r)
        else $error("power down not entered with nmi low");

    AST_PD_STAYS: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && power_down_r && !reset_hit |=> power_down_r)
        else $error("power down left without reset");

    AST_PD_NEEDS_INSTR: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && !power_down_r && !power_down_instruction |=> !power_down_r)
        else $error("power down entered without the instruction");

    AST_PD_IGNORE: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && run_ok(state_r, reset_hit) && power_down_instruction
        && sync_if.nmi_lvl |=> !power_down_r && pd_ignored_r)
        else $error("power down not ignored with nmi high");

    AST_IGN_PULSE: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && !power_down_instruction |=> !pd_ignored_r)
        else $error("ignore flag raised without the instruction");

    AST_IGN_RUNNING: assert property (
        @(posedge ref_clk) disable iff (rst)
        pd_ignored_r |-> !power_down_r && !sys_reset_r)
        else $error("ignore flag seen outside normal running");

    AST_CFG_CAPTURE: assert property (
        @(posedge ref_clk) disable iff (rst)
        $fell(sys_reset_r) |-> cfg_valid_r
        && startup_cfg_r[0] == $past(startup_config_pin_a)
        && startup_cfg_r[1] == $past(startup_config_pin_b))
        else $error("startup configuration not captured at reset end");

    AST_RESET_LEAVE: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && state_r == ST_IN_RESET && !sync_if.rst_req |=>
        !sys_reset_r && cfg_valid_r)
        else $error("reset end did not release the core");

    AST_CFG_STABLE: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en && !reset_hit && state_r != ST_IN_RESET |=>
        $stable(startup_cfg_r) && cfg_valid_r)
        else $error("startup configuration changed while running");
endmodule

// ---- sim/rnp_partner.sv ----
module rnp_partner (
    input wire logic ref_clk,
    output logic ext_reset_in_n,
    output logic nmi_in,
    output logic startup_config_pin_a,
    output logic startup_config_pin_b
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ext_reset_in_n = 1'b1;
        nmi_in = 1'b1; // idle pulled high
        {startup_config_pin_b, startup_config_pin_a} = 2'h2;
    end
    // low for n cycles, config settled before release
    task automatic hold_reset(input int n, input logic [1:0] cfg);
        ext_reset_in_n = 1'b0;
        repeat (n - 2) @(negedge ref_clk);
        {startup_config_pin_b, startup_config_pin_a} = cfg;
        repeat (2) @(negedge ref_clk);
        ext_reset_in_n = 1'b1;
    endtask
    task automatic spike(input int ns);
        ext_reset_in_n = 1'b0;
        #(ns);
        ext_reset_in_n = 1'b1;
    endtask
    task automatic set_nmi(input logic v);
        nmi_in = v;
    endtask
endmodule

// ---- sim/rnp_reset_nmi_pd_bench.sv ----
module rnp_reset_nmi_pd_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rnp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic osc_running = 1'b1;
    logic power_down_instruction = 1'b0;
    logic ext_reset_in_n, nmi_in, pin_a, pin_b;
    logic sys_reset_r, nmi_trap_r, power_down_r, pd_ignored_r, cfg_valid_r;
    rnp_cfg_t startup_cfg_r;
    int err_total = 0;
    int n_checks = 0;
    int n_trap = 0;
    int n_ign = 0;
    rnp_partner i_rnp_partner (.ref_clk(ref_clk),
        .ext_reset_in_n(ext_reset_in_n), .nmi_in(nmi_in),
        .startup_config_pin_a(pin_a), .startup_config_pin_b(pin_b));
    rnp_reset_nmi_pd i_rnp_reset_nmi_pd (.ref_clk(ref_clk), .rst(rst),
        .clk_en(clk_en), .ext_reset_in_n(ext_reset_in_n),
        .osc_running(osc_running), .nmi_in(nmi_in),
        .power_down_instruction(power_down_instruction),
        .startup_config_pin_a(pin_a), .startup_config_pin_b(pin_b),
        .sys_reset_r(sys_reset_r), .nmi_trap_r(nmi_trap_r),
        .power_down_r(power_down_r), .pd_ignored_r(pd_ignored_r),
        .startup_cfg_r(startup_cfg_r), .cfg_valid_r(cfg_valid_r));
    initial forever #4 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        n_trap += int'(nmi_trap_r === 1'b1);
        n_ign += int'(pd_ignored_r === 1'b1);
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input string what, input logic [1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic pd_pulse;
        power_down_instruction = 1'b1;
        cyc(1);
        power_down_instruction = 1'b0;
        cyc(2);
    endtask
    task automatic t_boot;
        cyc(8);
        rst = 1'b0;
        cyc(1);
        chk("sys_reset", {1'b0, sys_reset_r}, 2'h1);
        cyc(4);
        chk("sys_reset", {1'b0, sys_reset_r}, 2'h0);
        chk("cfg", startup_cfg_r, 2'h2);
        chk("cfg_valid", {1'b0, cfg_valid_r}, 2'h1);
        $display("t_boot done");
    endtask
    task automatic t_filter;
        i_rnp_partner.spike(6);
        cyc(10);
        chk("sys_reset", {1'b0, sys_reset_r}, 2'h0);
        osc_running = 1'b0;
        i_rnp_partner.hold_reset(16, 2'h1);
        cyc(6);
        chk("sys_reset", {1'b0, sys_reset_r}, 2'h0);
        osc_running = 1'b1;
        fork
            i_rnp_partner.hold_reset(16, 2'h1);
            begin
                cyc(7);
                chk("sys_reset", {1'b0, sys_reset_r}, 2'h1);
            end
        join
        cyc(5);
        chk("sys_reset", {1'b0, sys_reset_r}, 2'h0);
        chk("cfg", startup_cfg_r, 2'h1);
        $display("t_filter done");
    endtask
    task automatic t_nmi;
        n_trap = 0;
        i_rnp_partner.set_nmi(1'b0);
        cyc(5);
        i_rnp_partner.set_nmi(1'b1);
        cyc(3);
        chk("trap_count", 2'(n_trap), 2'h1);
        $display("t_nmi done");
    endtask
    task automatic t_pd;
        n_ign = 0;
        pd_pulse();
        chk("power_down", {1'b0, power_down_r}, 2'h0);
        chk("ignored_count", 2'(n_ign), 2'h1);
        i_rnp_partner.set_nmi(1'b0);
        cyc(4);
        pd_pulse();
        chk("power_down", {1'b0, power_down_r}, 2'h1);
        n_trap = 0;
        i_rnp_partner.set_nmi(1'b1);
        cyc(3);
        i_rnp_partner.set_nmi(1'b0);
        pd_pulse();
        cyc(2);
        chk("trap_count", 2'(n_trap), 2'h0);
        chk("ignored_count", 2'(n_ign), 2'h1);
        chk("power_down", {1'b0, power_down_r}, 2'h1);
        i_rnp_partner.hold_reset(16, 2'h3);
        i_rnp_partner.set_nmi(1'b1);
        cyc(5);
        chk("power_down", {1'b0, power_down_r}, 2'h0);
        chk("cfg", startup_cfg_r, 2'h3);
        chk("cfg_valid", {1'b0, cfg_valid_r}, 2'h1);
        $display("t_pd done");
    endtask
    task automatic t_freeze;
        n_trap = 0;
        n_ign = 0;
        clk_en = 1'b0;
        i_rnp_partner.set_nmi(1'b0);
        pd_pulse();
        cyc(3);
        chk("trap_count", 2'(n_trap), 2'h0);
        chk("power_down", {1'b0, power_down_r}, 2'h0);
        chk("ignored_count", 2'(n_ign), 2'h0);
        clk_en = 1'b1;
        cyc(4);
        chk("trap_count", 2'(n_trap), 2'h1);
        $display("t_freeze done");
    endtask
    initial begin
        t_boot();
        t_filter();
        t_nmi();
        t_pd();
        t_freeze();
        end_of_test();
    end
    initial begin
        #20000;
        err_total++;
        $display("unexpected timeout");
        end_of_test();
    end
endmodule
